// *** rtl/pctb_defines.vh ***
/*
  constants of the program counter, table and bank logic: operation codes,
  register byte offsets, reset values and bank maps.
  assumes it is included by its bare name from the design file.
*/
`ifndef PCTB_DEFINES_VH
`define PCTB_DEFINES_VH

// ==========================================================
// operation codes on op_code
`define PCTB_OP_W 5
`define PCTB_OP_NONE 5'h00
`define PCTB_OP_ABS_JUMP 5'h01
`define PCTB_OP_CALL 5'h02
`define PCTB_OP_LONG_CALL 5'h03
`define PCTB_OP_RETURN 5'h04
`define PCTB_OP_EXIT_LITERAL 5'h05
`define PCTB_OP_INT_EXIT 5'h06
`define PCTB_OP_INT_VECTOR 5'h07
`define PCTB_OP_LOW_READ 5'h08
`define PCTB_OP_LOW_WRITE 5'h09
`define PCTB_OP_LOW_RMW 5'h0a
`define PCTB_OP_LOAD_PBANK 5'h0b
`define PCTB_OP_LOAD_RBANK 5'h0c
`define PCTB_OP_LATCH_WRITE 5'h0d
`define PCTB_OP_LATCH_READ 5'h0e
`define PCTB_OP_WORD_WRITE 5'h0f
`define PCTB_OP_WORD_READ 5'h10
`define PCTB_OP_SKIP 5'h11

// ==========================================================
// register byte offsets on the register bus
`define PCTB_ADDR_W 8
`define PCTB_OFS_PTR_LOW 8'h00
`define PCTB_OFS_PTR_HIGH 8'h04
`define PCTB_OFS_COUNTER_LOW 8'h08
`define PCTB_OFS_HOLD_LATCH 8'h0c
`define PCTB_OFS_BANK_SEL 8'h10
`define PCTB_OFS_WORD_LATCH 8'h14
`define PCTB_OFS_STATUS 8'h18

// ==========================================================
// reset values and bus answers
`define PCTB_RST_PC 16'h0000
`define PCTB_RST_BYTE 8'h00
`define PCTB_RST_WORD 16'h0000
`define PCTB_RESP_OKAY 2'h0
`define PCTB_RESP_SLVERR 2'h2

// ==========================================================
// banking: banked peripheral window 10h..17h, implemented bank maps
`define PCTB_PERIPH_WIN 5'h02
`define PCTB_PBANK_MAP 16'h00ff
`define PCTB_RBANK_MAP 16'h000f

`endif

// *** rtl/pctb_core.v ***
/*
  program counter, counter high holding latch, table pointer, word latch and
  bank selector of an 8-bit core, with an axi4-lite register slave.
  assumes the core sequencer drives one operation at a time on op_valid,
  a fetch pulse in q1 on the same clock, and a program memory that answers
  a read with pm_rvalid some cycles later.
*/
`timescale 1ns/100ps
`include "pctb_defines.vh"

module pctb_core (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // core operation request
  input wire fetch_q1,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [15:0] op_literal,
  input wire [7:0] op_data,
  input wire op_hi,
  input wire op_inc,
  input wire [15:0] stack_top,
  output reg [7:0] op_rdata,
  output reg op_rvalid,
  output wire op_busy,
  // counter and stack
  output reg [15:0] pc,
  output reg forced_nop,
  output reg stack_push,
  output reg [15:0] push_addr,
  // program memory port
  input wire ext_mode,
  output reg pm_rd,
  output reg pm_wr,
  output reg pm_external,
  output reg [15:0] pm_addr,
  output reg [15:0] pm_wdata,
  input wire [15:0] pm_rdata,
  input wire pm_rvalid,
  // banked data memory gating
  input wire [7:0] dm_addr,
  input wire dm_ram_sel,
  input wire dm_wr,
  input wire [7:0] dm_rdata_raw,
  output wire [3:0] periph_bank,
  output wire [3:0] ram_bank,
  output wire dm_wr_en,
  output wire [7:0] dm_rdata,
  // axi4-lite register slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ==========================================================
  // state
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam [15:0] PBANK_MAP = `PCTB_PBANK_MAP;
  localparam [15:0] RBANK_MAP = `PCTB_RBANK_MAP;

  reg [7:0] counter_high_holding_latch;
  reg [15:0] table_pointer;
  reg [15:0] word_holding_latch;
  reg [7:0] bank_selector;
  reg [1:0] tstate;
  reg tinc;
  reg ext_meta;
  reg ext_sync;

  reg aw_held;
  reg [7:0] aw_addr_q;
  reg w_held;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [15:0] pc_inc;
  wire [15:0] ptr_inc;
  wire [15:0] wr_word;
  wire [7:0] latch_byte;
  wire tbl_op;
  wire bus_wr_go;
  wire bus_rd_go;
  wire wr_known;
  wire rd_known;
  wire in_periph_win;
  wire bank_ok;

  assign pc_inc = pc + 16'h0001;
  assign ptr_inc = table_pointer + 16'h0001;
  assign latch_byte = op_hi ? word_holding_latch[15:8] : word_holding_latch[7:0];
  assign wr_word = op_hi ? {op_data, word_holding_latch[7:0]}
                         : {word_holding_latch[15:8], op_data};
  assign tbl_op = (op_code == `PCTB_OP_LATCH_WRITE) || (op_code == `PCTB_OP_LATCH_READ) ||
                  (op_code == `PCTB_OP_WORD_WRITE) || (op_code == `PCTB_OP_WORD_READ);
  // a table read in flight owns the latch; the sequencer waits on op_busy
  assign op_busy = (tstate == ST_WAIT);

  // ==========================================================
  // bus handshakes: core operations win, the bus waits while op_valid is high
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign bus_wr_go = aw_held & w_held & ~s_axi_bvalid & ~op_valid;
  assign s_axi_arready = ~s_axi_rvalid & ~op_valid;
  assign bus_rd_go = s_axi_arvalid & s_axi_arready;

  assign wr_known = (aw_addr_q == `PCTB_OFS_PTR_LOW) || (aw_addr_q == `PCTB_OFS_PTR_HIGH) ||
                    (aw_addr_q == `PCTB_OFS_COUNTER_LOW) || (aw_addr_q == `PCTB_OFS_HOLD_LATCH) ||
                    (aw_addr_q == `PCTB_OFS_BANK_SEL);
  assign rd_known = wr_known_rd(s_axi_araddr);

  function wr_known_rd;
    input [7:0] a;
    begin
      wr_known_rd = (a == `PCTB_OFS_PTR_LOW) || (a == `PCTB_OFS_PTR_HIGH) ||
                    (a == `PCTB_OFS_COUNTER_LOW) || (a == `PCTB_OFS_HOLD_LATCH) ||
                    (a == `PCTB_OFS_BANK_SEL) || (a == `PCTB_OFS_WORD_LATCH) ||
                    (a == `PCTB_OFS_STATUS);
    end
  endfunction

  // ==========================================================
  // banked data memory gating
  assign periph_bank = bank_selector[3:0];
  assign ram_bank = bank_selector[7:4];
  assign in_periph_win = (dm_addr[7:3] == `PCTB_PERIPH_WIN);
  // bank 15 is unmapped, like peripheral banks 8 to 14 and ram banks 4 to 14; it reads zero
  assign bank_ok = dm_ram_sel ? RBANK_MAP[bank_selector[7:4]] :
                   in_periph_win ? PBANK_MAP[bank_selector[3:0]] :
                   1'b1;
  // status flags stay with the alu, which sees the zero read
  assign dm_wr_en = dm_wr & bank_ok;
  assign dm_rdata = bank_ok ? dm_rdata_raw : 8'h00;

  // ==========================================================
  // mode pin synchroniser
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= ext_mode;
      ext_sync <= ext_meta;
    end
  end

  // ==========================================================
  // counter, latches, pointer and table engine
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc <= `PCTB_RST_PC;
      counter_high_holding_latch <= `PCTB_RST_BYTE;
      table_pointer <= `PCTB_RST_WORD;
      word_holding_latch <= `PCTB_RST_WORD;
      bank_selector <= `PCTB_RST_BYTE;
      op_rdata <= `PCTB_RST_BYTE;
      op_rvalid <= 1'b0;
      forced_nop <= 1'b0;
      stack_push <= 1'b0;
      push_addr <= `PCTB_RST_PC;
      pm_rd <= 1'b0;
      pm_wr <= 1'b0;
      pm_external <= 1'b0;
      pm_addr <= `PCTB_RST_WORD;
      pm_wdata <= `PCTB_RST_WORD;
      tstate <= ST_IDLE;
      tinc <= 1'b0;
    end else begin
      op_rvalid <= 1'b0;
      stack_push <= 1'b0;
      pm_rd <= 1'b0;
      pm_wr <= 1'b0;
      if (fetch_q1) begin
        pc <= pc_inc;
        forced_nop <= 1'b0;
      end
      case (tstate)
        ST_IDLE: begin
          tstate <= ST_IDLE;
        end
        ST_WAIT: begin
          if (pm_rvalid) begin
            word_holding_latch <= pm_rdata;
            if (tinc)
              table_pointer <= ptr_inc;
            tstate <= ST_IDLE;
          end
        end
        default: begin
          tstate <= ST_IDLE;
        end
      endcase
      if (op_valid && !(tbl_op && op_busy)) begin
        case (op_code)
          `PCTB_OP_ABS_JUMP, `PCTB_OP_CALL: begin
            pc <= {pc[15:13], op_literal[12:0]};
            counter_high_holding_latch <= {pc[15:13], op_literal[12:8]};
            stack_push <= (op_code == `PCTB_OP_CALL);
            push_addr <= pc;
          end
          `PCTB_OP_LONG_CALL: begin
            pc <= {counter_high_holding_latch, op_literal[7:0]};
            stack_push <= 1'b1;
            push_addr <= pc;
          end
          `PCTB_OP_RETURN, `PCTB_OP_EXIT_LITERAL, `PCTB_OP_INT_EXIT: begin
            pc <= stack_top;
          end
          `PCTB_OP_INT_VECTOR: begin
            pc <= op_literal;
            stack_push <= 1'b1;
            push_addr <= pc;
          end
          `PCTB_OP_LOW_READ: begin
            op_rdata <= pc[7:0];
            op_rvalid <= 1'b1;
            counter_high_holding_latch <= pc[15:8];
          end
          `PCTB_OP_LOW_WRITE: begin
            pc <= {counter_high_holding_latch, op_data};
          end
          `PCTB_OP_LOW_RMW: begin
            // op_data is the alu result of the low byte shown on pc[7:0]
            pc <= {counter_high_holding_latch, op_data};
          end
          `PCTB_OP_LOAD_PBANK: begin
            bank_selector[3:0] <= op_literal[3:0];
          end
          `PCTB_OP_LOAD_RBANK: begin
            bank_selector[7:4] <= op_literal[3:0];
          end
          `PCTB_OP_LATCH_WRITE: begin
            word_holding_latch <= wr_word;
          end
          `PCTB_OP_LATCH_READ: begin
            op_rdata <= latch_byte;
            op_rvalid <= 1'b1;
          end
          `PCTB_OP_WORD_WRITE: begin
            word_holding_latch <= wr_word;
            pm_wr <= 1'b1;
            pm_addr <= table_pointer;
            pm_wdata <= wr_word;
            pm_external <= ext_sync;
            if (op_inc)
              table_pointer <= ptr_inc;
          end
          `PCTB_OP_WORD_READ: begin
            op_rdata <= latch_byte;
            op_rvalid <= 1'b1;
            pm_rd <= 1'b1;
            pm_addr <= table_pointer;
            pm_external <= ext_sync;
            tinc <= op_inc;
            tstate <= ST_WAIT;
          end
          `PCTB_OP_SKIP: begin
            forced_nop <= 1'b1;
          end
          default: begin
            forced_nop <= forced_nop;
          end
        endcase
      end else if (bus_wr_go && w_strb_q[0]) begin
        case (aw_addr_q)
          `PCTB_OFS_PTR_LOW: table_pointer[7:0] <= w_data_q[7:0];
          `PCTB_OFS_PTR_HIGH: table_pointer[15:8] <= w_data_q[7:0];
          `PCTB_OFS_COUNTER_LOW: pc <= {counter_high_holding_latch, w_data_q[7:0]};
          `PCTB_OFS_HOLD_LATCH: counter_high_holding_latch <= w_data_q[7:0];
          `PCTB_OFS_BANK_SEL: bank_selector <= w_data_q[7:0];
          default: counter_high_holding_latch <= counter_high_holding_latch;
        endcase
      end else if (bus_rd_go && (s_axi_araddr == `PCTB_OFS_COUNTER_LOW)) begin
        counter_high_holding_latch <= pc[15:8];
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel: address and data taken in either order
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCTB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (bus_wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `PCTB_RESP_OKAY : `PCTB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel; the status word shows the whole counter
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCTB_RESP_OKAY;
    end else begin
      if (bus_rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_known ? `PCTB_RESP_OKAY : `PCTB_RESP_SLVERR;
        case ({s_axi_araddr[7:2], 2'b00})
          `PCTB_OFS_PTR_LOW: s_axi_rdata <= {24'h000000, table_pointer[7:0]};
          `PCTB_OFS_PTR_HIGH: s_axi_rdata <= {24'h000000, table_pointer[15:8]};
          `PCTB_OFS_COUNTER_LOW: s_axi_rdata <= {24'h000000, pc[7:0]};
          `PCTB_OFS_HOLD_LATCH: s_axi_rdata <= {24'h000000, counter_high_holding_latch};
          `PCTB_OFS_BANK_SEL: s_axi_rdata <= {24'h000000, bank_selector};
          `PCTB_OFS_WORD_LATCH: s_axi_rdata <= {16'h0000, word_holding_latch};
          `PCTB_OFS_STATUS: s_axi_rdata <= {13'h0000, ext_sync, op_busy, 1'b0, pc};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pctb_core

// *** verif/pctb_monitor.sv ***
/*
  port checker of pctb_core: counter loads, low-byte reads, skips,
  table read start and bank gating.
  assumes one clock, core_clk, and the async active-low rstn.
*/
`timescale 1ns/100ps
`include "pctb_defines.vh"
module pctb_monitor (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // core operation
  input wire fetch_q1,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [15:0] op_literal,
  input wire [7:0] op_data,
  input wire [15:0] stack_top,
  input wire [7:0] op_rdata,
  input wire op_rvalid,
  input wire op_busy,
  input wire [15:0] pc,
  input wire forced_nop,
  input wire stack_push,
  input wire [15:0] push_addr,
  input wire pm_rd,
  // banked data memory
  input wire [7:0] dm_addr,
  input wire dm_ram_sel,
  input wire [3:0] periph_bank,
  input wire dm_wr_en,
  input wire [7:0] dm_rdata
);
  localparam logic [15:0] PMAP = `PCTB_PBANK_MAP;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ======
  // counter, table read and bank gating
  AST_FETCH_INC: assert property (fetch_q1 && !op_valid |=> pc == $past(pc) + 16'h1)
    else $error("pc did not advance on fetch");
  AST_JUMP: assert property (op_valid && op_code inside {`PCTB_OP_ABS_JUMP, `PCTB_OP_CALL}
    |=> pc == {$past(pc[15:13]), $past(op_literal[12:0])}) else $error("jump target wrong");
  AST_LONG_CALL: assert property (op_valid && op_code == `PCTB_OP_LONG_CALL
    |=> pc[7:0] == $past(op_literal[7:0]) && stack_push && push_addr == $past(pc))
    else $error("long call low byte or push wrong");
  AST_RETURN: assert property (op_valid && op_code inside {`PCTB_OP_RETURN,
    `PCTB_OP_EXIT_LITERAL, `PCTB_OP_INT_EXIT} |=> pc == $past(stack_top))
    else $error("return did not load stack entry");
  AST_VECTOR: assert property (op_valid && op_code == `PCTB_OP_INT_VECTOR
    |=> pc == $past(op_literal) && stack_push) else $error("vector not forced");
  AST_LOW_READ: assert property (op_valid && op_code == `PCTB_OP_LOW_READ
    |=> op_rvalid && op_rdata == $past(pc[7:0])) else $error("low byte read wrong");
  AST_RMW: assert property (op_valid && op_code == `PCTB_OP_LOW_RMW
    |=> pc[7:0] == $past(op_data)) else $error("rmw result not in low byte");
  AST_SKIP: assert property (op_valid && op_code == `PCTB_OP_SKIP && !fetch_q1
    |=> forced_nop) else $error("skip gave no forced nop");
  AST_TABLE_READ: assert property (op_valid && op_code == `PCTB_OP_WORD_READ && !op_busy
    |=> pm_rd && op_busy) else $error("table read did not start");
  AST_BANK_GATE: assert property (!dm_ram_sel && dm_addr[7:3] == `PCTB_PERIPH_WIN
    && !PMAP[periph_bank] |-> dm_rdata == 8'h00 && !dm_wr_en) else $error("bank not gated");
  cover property (op_valid && op_code == `PCTB_OP_WORD_READ);
  cover property (op_valid && op_code == `PCTB_OP_LOW_RMW);
  cover property (forced_nop);
endmodule // pctb_monitor

bind pctb_core pctb_monitor pctb_monitor_inst (.*);

// *** verif/pctb_memory_model.sv ***
/*
  program memory and raw banked data memory behind pctb_core.
  assumes pm_rd and pm_wr are one-cycle pulses; slow stretches the answer.
*/
`timescale 1ns/100ps
module pctb_memory_model (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  input wire slow,
  // program memory
  input wire pm_rd,
  input wire pm_wr,
  input wire pm_external,
  input wire [15:0] pm_addr,
  input wire [15:0] pm_wdata,
  output logic [15:0] pm_rdata,
  output logic pm_rvalid,
  // data memory
  input wire [7:0] dm_addr,
  input wire [3:0] periph_bank,
  output logic [7:0] dm_rdata_raw
);
  logic [15:0] mem [0:511];
  logic [3:0] cnt;
  logic [8:0] ra;
  logic [7:0] noise;
  initial for (int i = 0; i < 512; i++) mem[i] = {i[7:0] ^ 8'ha5, i[7:0]};
  // reserved bank gives garbage, so the core must mask it
  assign dm_rdata_raw = periph_bank == 4'hf ? noise : {periph_bank, dm_addr[3:0]};
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      pm_rvalid <= 1'b0;
      pm_rdata <= 16'h0000;
    end else begin
      noise <= 8'($urandom);
      pm_rvalid <= 1'b0;
      // idle bus toggles so a stale word is never mistaken for data
      pm_rdata <= ~pm_rdata;
      if (pm_wr) mem[{pm_external, pm_addr[7:0]}] <= pm_wdata;
      if (pm_rd) begin
        ra <= {pm_external, pm_addr[7:0]};
        cnt <= slow ? 4'h6 : 4'h1;
      end else if (cnt == 4'h1) begin
        pm_rvalid <= 1'b1;
        pm_rdata <= mem[ra];
        cnt <= 4'h0;
      end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule // pctb_memory_model

// *** verif/pctb_core_bench.sv ***
/*
  self-checking bench of pctb_core: axi4-lite master, core op driver and
  a queue scoreboard. assumes pctb_memory_model on the memory ports.
*/
`timescale 1ns/100ps
`include "pctb_defines.vh"
module pctb_core_bench;
  logic core_clk = 0, rstn = 0, fetch_q1 = 0, op_valid = 0, op_hi = 0, op_inc = 0;
  logic ext_mode = 0, slow = 0, dm_ram_sel = 0, dm_wr = 0, ok;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [4:0] op_code = '0;
  logic [15:0] op_literal = '0, stack_top = '0, e_pc = '0, e_ptr, e_wl = '0, w;
  logic [7:0] op_data = '0, dm_addr = '0, s_axi_awaddr = '0, s_axi_araddr = '0, e_lat, b, v;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire [7:0] op_rdata, dm_rdata_raw, dm_rdata;
  wire [15:0] pc, push_addr, pm_addr, pm_wdata, pm_rdata;
  wire [3:0] periph_bank, ram_bank;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire op_rvalid, op_busy, forced_nop, stack_push, pm_rd, pm_wr, pm_external, pm_rvalid;
  wire dm_wr_en, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_mismatch = 0, comparisons = 0;
  logic [33:0] q_rd [$];
  logic [7:0] q_op [$];
  logic [1:0] q_b [$];
  localparam logic [15:0] PMAP = `PCTB_PBANK_MAP;
  localparam logic [15:0] RMAP = `PCTB_RBANK_MAP;
  logic [4:0] codes [7] = '{`PCTB_OP_RETURN, `PCTB_OP_EXIT_LITERAL, `PCTB_OP_INT_EXIT,
    `PCTB_OP_INT_VECTOR, `PCTB_OP_LONG_CALL, `PCTB_OP_CALL, `PCTB_OP_ABS_JUMP};
  logic [7:0] bsel [5] = '{8'h03, 8'h09, 8'h0f, 8'h50, 8'h23};

  pctb_core pctb_core_inst (.*);
  pctb_memory_model pctb_memory_model_inst (.*);

  initial forever #4 core_clk = ~core_clk;

  // ======
  // reporting
  task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task timeout;
    n_mismatch++;
    finish_test;
  endtask

  // ======
  // drivers
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    int n = 0;
    q_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      n++;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 0;
    if (n >= 100) timeout;
    @(posedge core_clk);
  endtask
  task automatic rd(input [7:0] a, input [33:0] e);
    int n = 0;
    q_rd.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      n++;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 0;
    if (n >= 100) timeout;
    @(posedge core_clk);
  endtask
  task automatic rr(input [7:0] a, input [31:0] d);
    rd(a, {`PCTB_RESP_OKAY, d});
  endtask
  task automatic status;
    rr(`PCTB_OFS_STATUS, {13'h0, ext_mode, 2'b00, e_pc});
  endtask
  task automatic op(input [4:0] c, input [15:0] l, input [7:0] d, input h, input i);
    op_valid <= 1;
    op_code <= c;
    op_literal <= l;
    op_data <= d;
    op_hi <= h;
    op_inc <= i;
    @(posedge core_clk);
  endtask
  // drops the request and waits out a pending table read
  task automatic settle;
    int n = 0;
    op_valid <= 0;
    fetch_q1 <= 0;
    @(posedge core_clk);
    while (op_busy && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100) timeout;
    @(posedge core_clk);
  endtask

  // ======
  // scoreboard
  always @(posedge core_clk) begin
    if (op_rvalid) check("op_rdata", q_op.pop_front(), op_rdata);
    if (s_axi_rvalid && s_axi_rready)
      check("rdata", q_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) check("bresp", q_b.pop_front(), s_axi_bresp);
    if (pm_rd) check("pm_external", ext_mode, pm_external);
  end

  // ======
  // main sequence
  initial begin
    void'($urandom(12));
    repeat (20) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    for (int a = 0; a < 28; a += 4) rr(a[7:0], 32'h0);
    rd(8'h1c, {`PCTB_RESP_SLVERR, 32'h0});
    wr(`PCTB_OFS_WORD_LATCH, 32'h1, `PCTB_RESP_SLVERR);
    e_ptr = 16'($urandom);
    e_lat = 8'($urandom);
    wr(`PCTB_OFS_PTR_LOW, e_ptr[7:0], `PCTB_RESP_OKAY);
    wr(`PCTB_OFS_PTR_HIGH, e_ptr[15:8], `PCTB_RESP_OKAY);
    wr(`PCTB_OFS_HOLD_LATCH, e_lat, `PCTB_RESP_OKAY);
    rr(`PCTB_OFS_PTR_LOW, e_ptr[7:0]);
    rr(`PCTB_OFS_PTR_HIGH, e_ptr[15:8]);
    rr(`PCTB_OFS_HOLD_LATCH, e_lat);
    for (int k = 0; k < 3; k++) begin
      fetch_q1 <= 1;
      @(posedge core_clk);
    end
    settle;
    e_pc = 16'h0003;
    status;
    foreach (codes[j]) begin
      w = 16'($urandom);
      stack_top <= w;
      fetch_q1 <= 1;
      op(codes[j], ~w, 8'h00, 0, 0);
      settle;
      case (codes[j])
        `PCTB_OP_INT_VECTOR: e_pc = ~w;
        `PCTB_OP_LONG_CALL: e_pc = {e_lat, ~w[7:0]};
        `PCTB_OP_CALL, `PCTB_OP_ABS_JUMP: begin
          e_lat = {e_pc[15:13], ~w[12:8]};
          e_pc = {e_pc[15:13], ~w[12:0]};
        end
        default: e_pc = w;
      endcase
      status;
      rr(`PCTB_OFS_HOLD_LATCH, e_lat);
    end
    q_op.push_back(e_pc[7:0]);
    op(`PCTB_OP_LOW_READ, 16'h0, 8'h00, 0, 0);
    settle;
    rr(`PCTB_OFS_HOLD_LATCH, e_pc[15:8]);
    wr(`PCTB_OFS_HOLD_LATCH, 8'h03, `PCTB_RESP_OKAY);
    wr(`PCTB_OFS_COUNTER_LOW, 8'hf0, `PCTB_RESP_OKAY);
    e_pc = 16'h03f0;
    status;
    op(`PCTB_OP_LOW_RMW, 16'h0, 8'h20, 0, 0);
    settle;
    e_pc = 16'h0320;
    status;
    rr(`PCTB_OFS_HOLD_LATCH, 8'h03);
    op(`PCTB_OP_LOW_WRITE, 16'h0, 8'h55, 0, 0);
    settle;
    e_pc = 16'h0355;
    status;
    op(`PCTB_OP_SKIP, 16'h0, 8'h00, 0, 0);
    settle;
    b = 8'($urandom);
    op(`PCTB_OP_LOAD_PBANK, {12'h0, b[3:0]}, 8'h00, 0, 0);
    op(`PCTB_OP_LOAD_RBANK, {12'h0, b[7:4]}, 8'h00, 0, 0);
    settle;
    rr(`PCTB_OFS_BANK_SEL, b);
    foreach (bsel[j]) begin
      v = bsel[j];
      wr(`PCTB_OFS_BANK_SEL, v, `PCTB_RESP_OKAY);
      dm_ram_sel <= v[7:4] != 4'h0;
      dm_addr <= v[7:4] != 4'h0 ? 8'h41 : 8'h12;
      dm_wr <= 1;
      @(posedge core_clk);
      ok = v[7:4] != 4'h0 ? RMAP[v[7:4]] : PMAP[v[3:0]];
      check("dm_rdata", ok ? {v[3:0], dm_addr[3:0]} : 8'h00, dm_rdata);
      check("dm_wr_en", ok, dm_wr_en);
      check("ram_bank", v[7:4], ram_bank);
    end
    // slow memory, word out through the latch then back in
    slow <= 1;
    w = 16'($urandom);
    op(`PCTB_OP_LATCH_WRITE, 16'h0, w[15:8], 1, 0);
    op(`PCTB_OP_WORD_WRITE, 16'h0, w[7:0], 0, 1);
    settle;
    rr(`PCTB_OFS_WORD_LATCH, w);
    rr(`PCTB_OFS_PTR_LOW, 8'(e_ptr + 16'h1));
    wr(`PCTB_OFS_PTR_LOW, e_ptr[7:0], `PCTB_RESP_OKAY);
    q_op.push_back(w[7:0]);
    op(`PCTB_OP_WORD_READ, 16'h0, 8'h00, 0, 0);
    settle;
    q_op.push_back(w[15:8]);
    op(`PCTB_OP_LATCH_READ, 16'h0, 8'h00, 1, 0);
    settle;
    rr(`PCTB_OFS_PTR_LOW, e_ptr[7:0]);
    ext_mode <= 1;
    repeat (4) @(posedge core_clk);
    q_op.push_back(w[7:0]);
    op(`PCTB_OP_WORD_READ, 16'h0, 8'h00, 0, 1);
    op(`PCTB_OP_WORD_READ, 16'h0, 8'h00, 0, 1);
    settle;
    rr(`PCTB_OFS_WORD_LATCH, {e_ptr[7:0] ^ 8'ha5, e_ptr[7:0]});
    rr(`PCTB_OFS_PTR_LOW, 8'(e_ptr + 16'h1));
    status;
    finish_test;
  end
endmodule // pctb_core_bench
